// ### cfgomc_cell.sv
// One output cell: register, clock select, output enable and polarity
`timescale 1ns/1ps
`include "cfgomc_defines.svh"
module cfgomc_cell
  import cfgomc_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Static configuration
  input  wire logic [2:0] cfg_mode,
  input  wire logic       cfg_jk,
  input  wire logic       cfg_array_clk,
  input  wire logic [1:0] cfg_oe,
  input  wire logic       cfg_pol,
  input  wire logic       cfg_fb_inv,
  // Array terms, external clock enable and shared enable pin
  input  wire logic ext_clk_en,
  input  wire logic cell_array_clock,
  input  wire logic comb_term,
  input  wire logic j_term,
  input  wire logic k_term,
  input  wire logic flop_type_select_term,
  input  wire logic preset_term,
  input  wire logic cell_reset_term,
  input  wire logic preload_control_term,
  input  wire logic cell_output_enable_term,
  input  wire logic shared_output_enable_pin_n,
  // Pin
  input  wire logic cell_pin_in,
  output logic      cell_pin_out,
  output logic      cell_pin_oe,
  // Feedback to array and register state for status
  output logic      comb_feedback,
  output logic      reg_feedback,
  output logic      reg_state
);
  logic q_reg;
  logic q_next;
  logic clk_arr_reg;
  logic tick;
  logic jk_mode;
  logic oe_next;
  logic out_next;
  cfgomc_mode_t mode;
  cfgomc_oe_t   oe_sel;

  assign mode   = cfgomc_mode_t'(cfg_mode);
  assign oe_sel = cfgomc_oe_t'(cfg_oe);

  // Array clock edge as an enable; external clock is default RULE3 RULE6 RULE18
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clk_arr_reg <= 1'b0;
    else
      clk_arr_reg <= cell_array_clock;
  end
  assign tick = cfg_array_clk ? (cell_array_clock & ~clk_arr_reg) : ext_clk_en; // RULE3

  // Type term flips D/JK dynamically RULE16
  assign jk_mode = cfg_jk ^ flop_type_select_term;

  // Register next state: reset over preset over clocked update RULE3 RULE7 RULE15
  // Register feedback (true or inverted) and status take this value, so they never lag a preset
  always_comb
  begin
    q_next = q_reg;
    if (cell_reset_term)
      q_next = 1'b0; // RULE7
    else if (preset_term)
      q_next = 1'b1;
    else if (tick)
    begin
      if (preload_control_term)
        q_next = cell_pin_in; // RULE15
      else if (jk_mode)
        q_next = (j_term & ~q_reg) | (~k_term & q_reg);
      else
        q_next = j_term;
    end
  end

  // Cell register; power-on clear RULE14
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q_reg <= `CFGOMC_REG_RESET; // RULE14
    else
      q_reg <= q_next;
  end

  // Output enable source per cell RULE7 RULE8 RULE20
  always_comb
  begin
    unique case (oe_sel)
      CFGOMC_OE_ARRAY:  oe_next = cell_output_enable_term;
      CFGOMC_OE_PIN:    oe_next = ~shared_output_enable_pin_n; // RULE8
      CFGOMC_OE_ALWAYS: oe_next = 1'b1;
      default:          oe_next = 1'b0;
    endcase
    // Input modes never drive; preload forces release RULE2 RULE15
    if (mode == CFGOMC_INPUT_ONLY || mode == CFGOMC_REG_INPUT || preload_control_term)
      oe_next = 1'b0;
  end

  // Pin data: registered shows inverted Q, comb path via XOR RULE11 RULE12 RULE17
  assign out_next = (mode == CFGOMC_REG_OUTPUT) ? ~q_reg : (comb_term ^ cfg_pol);

  // Registered pin drivers; pin stays readable when released RULE20
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cell_pin_out <= 1'b1; // RULE14
      cell_pin_oe  <= 1'b0;
    end
    else
    begin
      cell_pin_out <= out_next;
      cell_pin_oe  <= oe_next;
    end
  end

  // Separate feedback paths for pin and hidden register RULE5 RULE13
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      comb_feedback <= 1'b0;
      reg_feedback  <= 1'b0;
      reg_state     <= 1'b0;
    end
    else
    begin
      comb_feedback <= cell_pin_in; // RULE20
      reg_feedback  <= q_next ^ cfg_fb_inv; // RULE13
      reg_state     <= q_next;
    end
  end
endmodule

// ### cfgomc_checker_properties.sv
// Checker for bus answers and pin relations of the output cell block
`timescale 1ns/1ps
module cfgomc_checker
  import cfgomc_pkg::*;
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Cells
  input wire logic        first_outer_cell_preload_term,
  input wire logic        last_outer_cell_preload_term,
  input wire logic [9:0]  cell_pin_oe,
  input wire logic [9:0]  cell_pin_out,
  input wire logic [9:0]  comb_feedback,
  input wire logic [9:0]  reg_feedback
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken at a given address
  sequence s_rd(logic [31:0] a);
    hsel && hready && htrans == 2'h2 && !hwrite && haddr == a;
  endsequence
  property p_ready;
    hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state or error response");
  property p_rst;
    $rose(hresetn) |-> cell_pin_out == 10'h3FF && cell_pin_oe == 10'h000 && reg_feedback == 10'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_hold;
    !(hsel && hready && htrans == 2'h2 && !hwrite) |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data changed without a read");
  property p_fb;
    s_rd(32'h10) |=> hrdata == {6'h0, $past(comb_feedback), 6'h0, $past(reg_feedback)};
  endproperty
  a_fb: assert property (p_fb) else $error("feedback readback wrong");
  property p_pins;
    s_rd(32'hC) |=> hrdata[31:16] == {6'h0, $past(cell_pin_oe)};
  endproperty
  a_pins: assert property (p_pins) else $error("enable readback wrong");
  property p_unmap;
    s_rd(32'h14) |=> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pre0;
    first_outer_cell_preload_term |=> !cell_pin_oe[0];
  endproperty
  a_pre0: assert property (p_pre0) else $error("first cell drives during load");
  property p_pre9;
    last_outer_cell_preload_term |=> !cell_pin_oe[9];
  endproperty
  a_pre9: assert property (p_pre9) else $error("last cell drives during load");
endmodule

bind cfgomc_top cfgomc_checker cfgomc_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .first_outer_cell_preload_term,
  .last_outer_cell_preload_term, .cell_pin_oe, .cell_pin_out, .comb_feedback, .reg_feedback);

// ### cfgomc_defines.svh
// Constants for the configurable output cell block
`ifndef CFGOMC_DEFINES_SVH
`define CFGOMC_DEFINES_SVH
`define CFGOMC_NUM_CELLS     10
`define CFGOMC_GROUP_SIZE    4
`define CFGOMC_NUM_XOR       12
`define CFGOMC_NUM_CONFIGS   14
`define CFGOMC_REG_RESET     1'b0
`define CFGOMC_ADDR_CELLSEL  32'h0000_0000
`define CFGOMC_ADDR_CFG      32'h0000_0004
`define CFGOMC_ADDR_STATUS   32'h0000_0008
`define CFGOMC_ADDR_PINS     32'h0000_000C
`define CFGOMC_ADDR_FB       32'h0000_0010
`define CFGOMC_CFG_MODE_LSB  0
`define CFGOMC_CFG_JK_BIT    3
`define CFGOMC_CFG_CLK_BIT   4
`define CFGOMC_CFG_OE_LSB    5
`define CFGOMC_CFG_POL_BIT   7
`define CFGOMC_CFG_FBINV_BIT 8
`define CFGOMC_CFG_RESET     9'h000
`endif

// ### cfgomc_pin_model.sv
// Model of the outside drivers that share the cell pins
`timescale 1ns/1ps
module cfgomc_pin_model
(
  // Clock
  input  wire logic       hclk,
  // Cell side
  input  wire logic [9:0] cell_pin_out,
  input  wire logic [9:0] cell_pin_oe,
  // Outside driver
  input  wire logic [9:0] ext_val,
  input  wire logic       ext_en,
  output logic      [9:0] cell_pin_in
);
  logic [9:0] last_reg = 10'h0;
  // Floating pins wander, so a stale level never passes
  always_ff @(posedge hclk)
    last_reg <= cell_pin_in;
  // Cell wins while enabled, else the outside driver
  always_comb
    for (int i = 0; i < 10; i++)
      cell_pin_in[i] = cell_pin_oe[i] ? cell_pin_out[i] : (ext_en ? ext_val[i] : ~last_reg[i]);
endmodule

// ### cfgomc_pkg.sv
// Types shared by the configurable output cell block
package cfgomc_pkg;
  typedef enum logic [2:0] {
    CFGOMC_COMB_IO,
    CFGOMC_INPUT_ONLY,
    CFGOMC_COMB_HIDDEN,
    CFGOMC_REG_INPUT,
    CFGOMC_REG_OUTPUT
  } cfgomc_mode_t;
  typedef enum logic [1:0] {
    CFGOMC_OE_ARRAY,
    CFGOMC_OE_PIN,
    CFGOMC_OE_ALWAYS,
    CFGOMC_OE_NEVER
  } cfgomc_oe_t;
endpackage

// ### cfgomc_top.sv
// Ten configurable output cells with AHB-Lite configuration access
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cfgomc_defines.svh"
// Notes on behaviour
// RULE1 - Ten cells, each independently configurable
// RULE2 - Five basic modes incl. hidden register
// RULE3 - Register JK or D, array/external clock
// RULE4 - Fourteen distinct combined configurations
// RULE5 - Bypassed register keeps running with feedback
// RULE6 - Eleven clocks: ten array, one external
// RULE7 - Per-cell enable and reset array terms
// RULE8 - Enable optionally from shared low pin
// RULE9 - Inner eight share preset/load in fours
// RULE10 - Outer cells own preset and load
// RULE11 - Combinatorial polarity via twelve XOR stages
// RULE12 - Register polarity set by equations
// RULE13 - Hidden register feedback true or inverted
// RULE14 - Registers clear at reset; pins high
// RULE15 - Load term preloads register from pin
// RULE16 - Type term switches D and JK
// RULE17 - Registered output drives inverted Q
// RULE18 - Default clock is external clock
// RULE19 - Configuration static, not from cell logic
// RULE20 - Disabled pin floats, still readable
module cfgomc_top
  import cfgomc_pkg::*;
#(
  parameter int NUM_CELLS = `CFGOMC_NUM_CELLS,
  parameter int NUM_XOR   = `CFGOMC_NUM_XOR
)
(
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Shared clock and pin
  input  wire logic        ext_clk_en,
  input  wire logic        shared_output_enable_pin_n,
  // Per-cell array terms and the shared type term
  input  wire logic [9:0]  cell_array_clock,
  input  wire logic [9:0]  comb_term,
  input  wire logic [9:0]  j_term,
  input  wire logic [9:0]  k_term,
  input  wire logic [9:0]  cell_reset_term,
  input  wire logic [9:0]  cell_output_enable_term,
  input  wire logic        flop_type_select_term,
  // Shared and outer preset/load terms
  input  wire logic        preset_group_a_term,
  input  wire logic        preset_group_b_term,
  input  wire logic        preload_group_a_term,
  input  wire logic        preload_group_b_term,
  input  wire logic        first_outer_cell_preset_term,
  input  wire logic        first_outer_cell_preload_term,
  input  wire logic        last_outer_cell_preset_term,
  input  wire logic        last_outer_cell_preload_term,
  // Extra XOR stages for the two bidirectional ports
  input  wire logic [1:0]  aux_comb_term,
  output logic [1:0]       aux_comb_out,
  // Cell pins
  input  wire logic [9:0]  cell_pin_in,
  output logic [9:0]       cell_pin_out,
  output logic [9:0]       cell_pin_oe,
  // Feedback into the array
  output logic [9:0]       comb_feedback,
  output logic [9:0]       reg_feedback
);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Elaboration-time guard: grouping is fixed to 1+4+4+1
  if (NUM_CELLS != `CFGOMC_NUM_CELLS || NUM_XOR != `CFGOMC_NUM_XOR)
  begin : g_bad_param
    $error("cfgomc_top: cell and XOR counts are fixed by the preset grouping");
  end

  // Static configuration per cell and XOR word RULE19
  logic [8:0]  cfg_reg [NUM_CELLS];
  logic [3:0]  cellsel_reg;
  logic [1:0]  aux_pol_reg;
  logic [9:0]  preset_vec;
  logic [9:0]  preload_vec;
  logic [9:0]  reg_state;
  logic [9:0]  pin_out_w;
  logic [9:0]  pin_oe_w;
  logic [9:0]  comb_fb_w;
  logic [9:0]  reg_fb_w;

  // AHB address phase capture
  logic        dp_valid_reg;
  logic        dp_write_reg;
  logic [31:0] dp_addr_reg;
  logic        ap_valid;

  // Legal mode decode used on configuration writes only
  function automatic logic cfg_legal(input logic [8:0] c);
    cfg_legal = (c[2:0] <= 3'h4);
  endfunction

  assign ap_valid = hsel & hready & (htrans == HTRANS_NONSEQ);

  // Address phase register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 32'h0000_0000;
    end
    else if (hready)
    begin
      dp_valid_reg <= ap_valid;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Cell select and aux polarity writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cellsel_reg <= 4'h0;
      aux_pol_reg <= 2'h0;
    end
    else if (dp_valid_reg && dp_write_reg && dp_addr_reg == `CFGOMC_ADDR_CELLSEL)
    begin
      if (hwdata[3:0] < 4'(NUM_CELLS))
        cellsel_reg <= hwdata[3:0];
      aux_pol_reg <= hwdata[9:8]; // RULE11
    end
  end

  // Configuration words; illegal mode codes are dropped RULE1 RULE4 RULE19
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++)
    begin : g_cfg
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cfg_reg[gi] <= `CFGOMC_CFG_RESET; // RULE18
        else if (dp_valid_reg && dp_write_reg && dp_addr_reg == `CFGOMC_ADDR_CFG
                 && cellsel_reg == 4'(gi) && cfg_legal(hwdata[8:0]))
          cfg_reg[gi] <= hwdata[8:0];
      end
    end
  endgenerate

  // Preset/load grouping: outer own, inner shared by four RULE9 RULE10
  always_comb
  begin
    preset_vec  = {NUM_CELLS{1'b0}};
    preload_vec = {NUM_CELLS{1'b0}};
    preset_vec[0]  = first_outer_cell_preset_term; // RULE10
    preload_vec[0] = first_outer_cell_preload_term;
    preset_vec[9]  = last_outer_cell_preset_term;
    preload_vec[9] = last_outer_cell_preload_term;
    for (int i = 1; i <= `CFGOMC_GROUP_SIZE; i++)
    begin
      preset_vec[i]  = preset_group_a_term; // RULE9
      preload_vec[i] = preload_group_a_term;
      preset_vec[i + `CFGOMC_GROUP_SIZE]  = preset_group_b_term;
      preload_vec[i + `CFGOMC_GROUP_SIZE] = preload_group_b_term;
    end
  end

  // The ten cells RULE1 RULE2 RULE5
  generate
    for (gi = 0; gi < NUM_CELLS; gi++)
    begin : g_cell
      cfgomc_cell u_cell (
        .hclk                       (hclk),
        .hresetn                    (hresetn),
        .cfg_mode                   (cfg_reg[gi][`CFGOMC_CFG_MODE_LSB +: 3]),
        .cfg_jk                     (cfg_reg[gi][`CFGOMC_CFG_JK_BIT]),
        .cfg_array_clk              (cfg_reg[gi][`CFGOMC_CFG_CLK_BIT]),
        .cfg_oe                     (cfg_reg[gi][`CFGOMC_CFG_OE_LSB +: 2]),
        .cfg_pol                    (cfg_reg[gi][`CFGOMC_CFG_POL_BIT]),
        .cfg_fb_inv                 (cfg_reg[gi][`CFGOMC_CFG_FBINV_BIT]),
        .ext_clk_en                 (ext_clk_en),
        .cell_array_clock           (cell_array_clock[gi]),
        .comb_term                  (comb_term[gi]),
        .j_term                     (j_term[gi]),
        .k_term                     (k_term[gi]),
        .flop_type_select_term      (flop_type_select_term),
        .preset_term                (preset_vec[gi]),
        .cell_reset_term            (cell_reset_term[gi]),
        .preload_control_term       (preload_vec[gi]),
        .cell_output_enable_term    (cell_output_enable_term[gi]),
        .shared_output_enable_pin_n (shared_output_enable_pin_n),
        .cell_pin_in                (cell_pin_in[gi]),
        .cell_pin_out               (pin_out_w[gi]),
        .cell_pin_oe                (pin_oe_w[gi]),
        .comb_feedback              (comb_fb_w[gi]),
        .reg_feedback               (reg_fb_w[gi]),
        .reg_state                  (reg_state[gi])
      );
    end
  endgenerate

  // Cell outputs are flops inside each cell; plain wiring here
  assign cell_pin_out  = pin_out_w;
  assign cell_pin_oe   = pin_oe_w;
  assign comb_feedback = comb_fb_w;
  assign reg_feedback  = reg_fb_w;

  // Two remaining XOR stages of the twelve RULE11
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aux_comb_out <= 2'h0;
    else
      aux_comb_out <= aux_comb_term ^ aux_pol_reg;
  end

  // Read data in the data phase; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_valid && !hwrite)
    begin
      unique case (haddr)
        `CFGOMC_ADDR_CELLSEL: hrdata <= {22'h0, aux_pol_reg, 4'h0, cellsel_reg};
        `CFGOMC_ADDR_CFG:     hrdata <= {23'h0, cfg_reg[cellsel_reg]};
        `CFGOMC_ADDR_STATUS:  hrdata <= {22'h0, reg_state};
        `CFGOMC_ADDR_PINS:    hrdata <= {6'h0, pin_oe_w, 6'h0, cell_pin_in};
        `CFGOMC_ADDR_FB:      hrdata <= {6'h0, comb_fb_w, 6'h0, reg_fb_w};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ### tb.sv
// Self-checking bench for the configurable output cell block
`timescale 1ns/1ps
`include "cfgomc_defines.svh"
module tb;
  import cfgomc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        ext_clk_en = 1'b0;
  logic        shared_output_enable_pin_n = 1'b1;
  logic        flop_type_select_term = 1'b0;
  logic [9:0]  cell_array_clock = 10'h0;
  logic [9:0]  comb_term = 10'h0;
  logic [9:0]  j_term = 10'h0;
  logic [9:0]  k_term = 10'h0;
  logic [9:0]  cell_reset_term = 10'h0;
  logic [9:0]  cell_output_enable_term = 10'h0;
  logic [3:0]  pre = 4'h0;
  logic        first_outer_cell_preload_term = 1'b0;
  logic        last_outer_cell_preload_term = 1'b0;
  logic [1:0]  aux_comb_term = 2'h0;
  logic [1:0]  aux_comb_out;
  logic [9:0]  cell_pin_in;
  logic [9:0]  cell_pin_out;
  logic [9:0]  cell_pin_oe;
  logic [9:0]  comb_feedback;
  logic [9:0]  reg_feedback;
  logic [9:0]  ext_val = 10'h0;
  logic        ext_en = 1'b0;
  logic [9:0]  pexp [4] = '{10'h01E, 10'h1E0, 10'h001, 10'h200};
  int          num_errors = 0;
  int          compares = 0;
  int          i;
  assign hready = hreadyout;
  cfgomc_top cfgomc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .ext_clk_en, .shared_output_enable_pin_n,
    .cell_array_clock, .comb_term, .j_term, .k_term, .cell_reset_term,
    .cell_output_enable_term, .flop_type_select_term, .preset_group_a_term(pre[0]),
    .preset_group_b_term(pre[1]), .preload_group_a_term(1'b0), .preload_group_b_term(1'b0),
    .first_outer_cell_preset_term(pre[2]), .first_outer_cell_preload_term,
    .last_outer_cell_preset_term(pre[3]), .last_outer_cell_preload_term, .aux_comb_term,
    .aux_comb_out, .cell_pin_in, .cell_pin_out, .cell_pin_oe, .comb_feedback, .reg_feedback);
  cfgomc_pin_model cfgomc_pin_model_i (.hclk, .cell_pin_out, .cell_pin_oe, .ext_val, .ext_en,
    .cell_pin_in);
  // 25 MHz clock
  initial
    forever #20 hclk = ~hclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single-word transfer; waits on hready, never on a cycle count
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic cfg(input logic [31:0] k, input logic [31:0] v);
    wr(`CFGOMC_ADDR_CELLSEL, k);
    wr(`CFGOMC_ADDR_CFG, v);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // One external clock pulse, then let pins settle
  task automatic tick();
    ext_clk_en <= 1'b1;
    @(posedge hclk);
    ext_clk_en <= 1'b0;
    wt(2);
  endtask
  task automatic clr();
    cell_reset_term <= 10'h3FF;
    @(posedge hclk);
    cell_reset_term <= 10'h0;
    pre <= 4'h0;
    @(posedge hclk);
  endtask
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    repeat (30000) @(posedge hclk);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    chk({22'h0, cell_pin_out}, 32'h3FF);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`CFGOMC_ADDR_STATUS, 32'h0);
    rc(`CFGOMC_ADDR_CFG, 32'h0);
    $display("test reset done");
    cfg(32'h3, 32'hCC);
    rc(`CFGOMC_ADDR_CFG, 32'hCC);
    wr(`CFGOMC_ADDR_CFG, 32'h5);
    rc(`CFGOMC_ADDR_CFG, 32'hCC);
    wr(`CFGOMC_ADDR_CELLSEL, 32'h30A);
    rc(`CFGOMC_ADDR_CELLSEL, 32'h303);
    chk({30'h0, aux_comb_out}, 32'h3);
    wr(`CFGOMC_ADDR_CELLSEL, 32'h0);
    rc(32'h14, 32'h0);
    $display("test registers done");
    for (i = 0; i < 10; i++)
      cfg(32'(i), 32'h44);
    j_term <= 10'h2AA;
    tick();
    chk({22'h0, cell_pin_out}, 32'h155);
    rc(`CFGOMC_ADDR_STATUS, 32'h2AA);
    flop_type_select_term <= 1'b1;
    j_term <= 10'h3FF;
    k_term <= 10'h3FF;
    tick();
    rc(`CFGOMC_ADDR_STATUS, 32'h155);
    j_term <= 10'h0;
    tick();
    rc(`CFGOMC_ADDR_STATUS, 32'h0);
    $display("test register types done");
    for (i = 0; i < 4; i++)
    begin
      pre <= 4'(1 << i);
      @(posedge hclk);
      pre <= 4'h0;
      rc(`CFGOMC_ADDR_STATUS, {22'h0, pexp[i]});
      clr();
    end
    pre <= 4'hF;
    clr();
    rc(`CFGOMC_ADDR_STATUS, 32'h0);
    $display("test preset groups done");
    flop_type_select_term <= 1'b0;
    cfg(32'h0, 32'h1C2);
    comb_term <= 10'h001;
    j_term <= 10'h001;
    tick();
    chk({31'h0, cell_pin_out[0]}, 32'h0);
    rc(`CFGOMC_ADDR_STATUS, 32'h1);
    rc(`CFGOMC_ADDR_FB, 32'h03FE0000);
    $display("test hidden register done");
    ext_en <= 1'b1;
    cfg(32'h0, 32'h22);
    shared_output_enable_pin_n <= 1'b0;
    wt(3);
    chk({31'h0, cell_pin_oe[0]}, 32'h1);
    shared_output_enable_pin_n <= 1'b1;
    wt(3);
    rc(`CFGOMC_ADDR_PINS, 32'h03FE03FE);
    cfg(32'h0, 32'h41);
    wt(3);
    chk({31'h0, cell_pin_oe[0]}, 32'h0);
    $display("test output enable done");
    cfg(32'h0, 32'h54);
    clr();
    j_term <= 10'h3FF;
    cell_array_clock <= 10'h001;
    wt(2);
    cell_array_clock <= 10'h0;
    rc(`CFGOMC_ADDR_STATUS, 32'h1);
    ext_val <= 10'h3FF;
    j_term <= 10'h0;
    cfg(32'h0, 32'h04);
    cell_output_enable_term <= 10'h001;
    first_outer_cell_preload_term <= 1'b1;
    last_outer_cell_preload_term <= 1'b1;
    ext_clk_en <= 1'b1;
    wt(3);
    chk({31'h0, cell_pin_oe[0]}, 32'h0);
    first_outer_cell_preload_term <= 1'b0;
    last_outer_cell_preload_term <= 1'b0;
    ext_clk_en <= 1'b0;
    rc(`CFGOMC_ADDR_STATUS, 32'h201);
    $display("test clocks and preload done");
    conclude();
  end
endmodule
